// >>> sadc_pkg.sv
// Constants, types and helpers for the serial converter sequencer
package sadc_pkg;

    // ******************************************************
    // Conversion timing, in system clock cycles
    // ******************************************************
    localparam int SADC_CONV_CYCLES = 36;
    localparam int SADC_ACQ_CYCLES  = 12;
    localparam int SADC_STEP_CYCLES = 3;
    localparam int SADC_RES_BITS    = 8;
    localparam logic [5:0] SADC_CONV_LAST = 6'(SADC_CONV_CYCLES - 1);
    localparam logic [5:0] SADC_ACQ_LAST  = 6'(SADC_ACQ_CYCLES - 1);
    localparam logic [1:0] SADC_STEP_LAST = 2'(SADC_STEP_CYCLES - 1);
    localparam logic [1:0] SADC_CS_BLANK  = 2'h3;

    // ******************************************************
    // Frame and channel constants
    // ******************************************************
    localparam logic [3:0] SADC_FRAME_EDGES = 4'h8;
    localparam logic [3:0] SADC_LAST_EDGE   = 4'h7;
    localparam logic [4:0] SADC_SELFTEST_CH = 5'h13;
    localparam logic [7:0] SADC_SAR_MSB     = 8'h80;

    // ******************************************************
    // Types
    // ******************************************************
    typedef enum logic [1:0] {SADC_IDLE, SADC_ACQ, SADC_SAR} sadc_phase_t;

    // Analog front-end controls, all registered
    typedef struct packed {
        logic       hold;
        logic [4:0] mux_sel;
        logic [7:0] dac;
    } sadc_ana_t;

    typedef struct packed {
        logic [1:0]  cs_s;
        logic [1:0]  clk_s;
        logic [1:0]  addr_s;
        logic [1:0]  cmp_s;
        logic [1:0]  mode_s;
        logic [1:0]  hreq_s;
        logic        cs_q;
        logic        clk_q;
        logic [1:0]  blank;
        logic [3:0]  edge_cnt;
        logic [7:0]  shift_in;
        logic [7:0]  shift_out;
        logic [4:0]  chan_store;
        sadc_phase_t phase;
        logic [5:0]  cnt;
        logic [1:0]  step;
        logic [7:0]  sar;
        logic [7:0]  mask;
        logic [7:0]  result;
        logic        sdo;
        logic        sdo_oe;
        logic        busy;
        sadc_ana_t   ana;
    } sadc_state_t;

    // Addresses whose low five bits lie beyond the last input select the self-test source; upper bits are ignored
    function automatic logic [4:0] sadc_chan(input logic [7:0] addr);
        sadc_chan = (addr[4:0] > SADC_SELFTEST_CH) ? SADC_SELFTEST_CH
                                                   : addr[4:0];
    endfunction : sadc_chan

endpackage : sadc_pkg

// >>> sadc_top.sv
// Control and serial interface of the 8-bit serial converter sequencer
`timescale 1ns/100ps
// ******************************************************
// ******************************************************
module sadc_top
    import sadc_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      resetn,
    input  wire logic      cs_n,
    input  wire logic      io_clk,
    input  wire logic      addr_in,
    input  wire logic      cmp_in,
    input  wire logic      sh_host_mode,
    input  wire logic      sh_hold_req,
    output logic           sdo,
    output logic           sdo_oe,
    output logic           conv_busy,
    output sadc_ana_t      ana
);

    localparam sadc_state_t SADC_RESET = '{
        cs_s: 2'h3, clk_s: 2'h0, addr_s: 2'h0, cmp_s: 2'h0,
        mode_s: 2'h0, hreq_s: 2'h0, cs_q: 1'b1, clk_q: 1'b0,
        blank: 2'h0, edge_cnt: 4'h0, shift_in: 8'h00,
        shift_out: 8'h00, chan_store: 5'h00, phase: SADC_IDLE,
        cnt: 6'h00, step: 2'h0, sar: 8'h00, mask: 8'h00,
        result: 8'h00, sdo: 1'b0, sdo_oe: 1'b0, busy: 1'b0,
        ana: '{hold: 1'b0, mux_sel: 5'h00, dac: 8'h00}};

    sadc_state_t st;
    sadc_state_t next_st;
    logic        cs_edge;
    logic        active;
    logic        io_rise;
    logic        io_fall;
    logic        host_hold;
    logic        take_bit;

    // ******************************************************
    // Edge detection on synchronised pins
    // ******************************************************
    // Shift clock is oversampled; it must stay well below sys_clk
    assign cs_edge   = st.cs_s[1] != st.cs_q;
    assign io_rise   = st.clk_s[1] & ~st.clk_q;
    assign io_fall   = ~st.clk_s[1] & st.clk_q;
    assign active    = ~st.cs_q & ~cs_edge & (st.blank == 2'h0);
    assign host_hold = st.mode_s[1] & st.hreq_s[1];
    assign take_bit  = active & (st.edge_cnt < SADC_FRAME_EDGES);

    // ******************************************************
    // Next-state logic
    // ******************************************************
    always_comb begin
        next_st = st;
        // Two-stage synchronisers for every pin except sys_clk and resetn
        next_st.cs_s   = {st.cs_s[0], cs_n};
        next_st.clk_s  = {st.clk_s[0], io_clk};
        next_st.addr_s = {st.addr_s[0], addr_in};
        next_st.cmp_s  = {st.cmp_s[0], cmp_in};
        next_st.mode_s = {st.mode_s[0], sh_host_mode};
        next_st.hreq_s = {st.hreq_s[0], sh_hold_req};
        next_st.cs_q   = st.cs_s[1];
        next_st.clk_q  = st.clk_s[1];
        if (st.blank != 2'h0) begin
            next_st.blank = st.blank - 2'h1;
        end

        // Conversion sequencer
        case (st.phase)
            SADC_IDLE: begin
                next_st.ana.hold = host_hold;
            end
            SADC_ACQ: begin
                next_st.ana.hold = host_hold;
                next_st.cnt = st.cnt + 6'h01;
                if (st.cnt == SADC_ACQ_LAST) begin
                    next_st.phase    = SADC_SAR;
                    next_st.ana.hold = 1'b1;
                    next_st.sar      = 8'h00;
                    next_st.mask     = SADC_SAR_MSB;
                    next_st.ana.dac  = SADC_SAR_MSB;
                    next_st.step     = 2'h0;
                end
            end
            SADC_SAR: begin
                // Comparator reaches us through two flops, so each
                // trial is held three cycles before it is judged
                next_st.ana.hold = 1'b1;
                next_st.cnt  = st.cnt + 6'h01;
                next_st.step = st.step + 2'h1;
                if (st.step == SADC_STEP_LAST) begin
                    next_st.step = 2'h0;
                    // A stuck-high comparator yields all ones
                    if (st.cmp_s[1]) begin
                        next_st.sar = st.sar | st.mask;
                    end
                    next_st.mask    = st.mask >> 1;
                    next_st.ana.dac = next_st.sar | (st.mask >> 1);
                    if (st.cnt == SADC_CONV_LAST) begin
                        next_st.result = next_st.sar;
                        next_st.phase  = SADC_IDLE;
                        next_st.busy   = 1'b0;
                    end
                end
            end
            default: begin
                next_st.phase = SADC_IDLE;
                next_st.busy  = 1'b0;
            end
        endcase

        // Serial frame; a start here overrides a running conversion
        if (cs_edge) begin
            next_st.blank = SADC_CS_BLANK;
            if (!st.cs_s[1]) begin
                next_st.edge_cnt  = 4'h0;
                next_st.shift_out = st.result;
                next_st.sdo       = st.result[7];
                next_st.sdo_oe    = 1'b1;
            end else begin
                next_st.sdo_oe = 1'b0;
            end
        end else if (take_bit && io_rise) begin
            next_st.shift_in = {st.shift_in[6:0], st.addr_s[1]};
        end else if (take_bit && io_fall) begin
            next_st.edge_cnt = st.edge_cnt + 4'h1;
            if (st.edge_cnt < SADC_LAST_EDGE) begin
                // Result leaves on the same clock as the address
                next_st.shift_out = {st.shift_out[6:0], 1'b0};
                next_st.sdo       = st.shift_out[6];
            end else begin
                next_st.chan_store  = sadc_chan(st.shift_in);
                next_st.ana.mux_sel = sadc_chan(st.shift_in);
                next_st.phase       = SADC_ACQ;
                next_st.busy        = 1'b1;
                next_st.cnt         = 6'h00;
                next_st.ana.hold    = host_hold;
            end
        end
    end

    // ******************************************************
    // State register
    // ******************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= SADC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign sdo       = st.sdo;
    assign sdo_oe    = st.sdo_oe;
    assign conv_busy = st.busy;
    assign ana       = st.ana;

    // ******************************************************
    // Assertions
    // ******************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic start_ev;
    assign start_ev = take_bit & ~io_rise & io_fall & ~cs_edge
                      & (st.edge_cnt == SADC_LAST_EDGE);

    sequence s_start;
        start_ev;
    endsequence
    sequence s_started;
        st.busy && st.phase == SADC_ACQ && st.cnt == 6'h00;
    endsequence

    a_conv_span: assert property (
        $rose(st.busy) |-> ##36 $fell(st.busy))
        else $error("conversion did not last 36 cycles");
    a_start_eighth: assert property (
        s_start |=> s_started)
        else $error("conversion not started at eighth fall");
    a_addr_store: assert property (
        s_start |=> st.chan_store == sadc_chan($past(st.shift_in))
                    && ana.mux_sel == st.chan_store)
        else $error("address not latched at start");
    a_msb_first: assert property (
        (cs_edge && !st.cs_s[1]) |=> sdo_oe && sdo == st.result[7])
        else $error("msb not presented on select fall");
    a_shift_out_bit: assert property (
        (take_bit && io_fall && st.edge_cnt < SADC_LAST_EDGE)
        |=> sdo == $past(st.shift_out[6]))
        else $error("result bit not shifted on fall");
    a_blank_inputs: assert property (
        cs_edge |-> ##2 ($stable(st.shift_in) && $stable(st.edge_cnt))[*3])
        else $error("control input taken during blanking");
    a_oe_follows_cs: assert property (
        st.cs_q && $past(st.cs_q) |-> !sdo_oe)
        else $error("output driven while deselected");
    a_addr_sample: assert property (
        (take_bit && io_rise && !cs_edge)
        |=> st.shift_in == {$past(st.shift_in[6:0]), $past(st.addr_s[1])})
        else $error("address bit not sampled on rise");
    a_hold_in_sar: assert property (
        st.phase == SADC_SAR |-> ana.hold)
        else $error("sample not held during approximation");
    a_chan_range: assert property (
        st.chan_store <= SADC_SELFTEST_CH)
        else $error("channel outside selector range");

endmodule : sadc_top

// >>> sadc_host.sv
// Host-side partner model: frames chip select, shift clock and address
`timescale 1ns/100ps
module sadc_host (
    input  wire logic sys_clk,
    input  wire logic data_line,
    output logic      cs_n,
    output logic      io_clk,
    output logic      addr_in
);
    time t_fall8;

    initial begin
        cs_n    = 1'b1;
        io_clk  = 1'b0;
        addr_in = 1'b0;
        t_fall8 = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // One whole frame: 8 address bits out, 8 result bits back
    task automatic frame(input logic [7:0] addr, output logic [7:0] rd,
                         output logic z_after);
        cs_n = 1'b0;
        tick(6); // Chip select setup before any shift edge
        for (int i = 7; i >= 0; i--) begin
            addr_in = addr[i]; // MSB first, set up before the rise
            tick(2);
            io_clk = 1'b1;
            tick(4);
            rd[i] = data_line; // Read and write in one frame
            io_clk = 1'b0;
            t_fall8 = $time;
            tick(4);
        end
        // Released line shows the inverse, never a stale level
        addr_in = ~addr_in;
        cs_n = 1'b1;
        tick(4);
        z_after = data_line;
        tick(36); // Chip select high during conversion
    endtask : frame
endmodule : sadc_host

// >>> serial_adc_sequencer_test.sv
// Self-checking bench for the serial converter sequencer
`timescale 1ns/100ps
module serial_adc_sequencer_test;
    import sadc_pkg::*;
    logic       sys_clk, resetn, cmp_in, sh_host_mode, sh_hold_req;
    logic       cs_n, io_clk, addr_in, sdo, sdo_oe, conv_busy, hold_seen;
    wire        data_line;
    sadc_ana_t  ana;
    logic [7:0] vin;
    logic [4:0] mux_seen;
    int         err_count, samples_checked, run, busy_len;
    time        t_busy;

    sadc_top dut (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
        .io_clk(io_clk), .addr_in(addr_in), .cmp_in(cmp_in),
        .sh_host_mode(sh_host_mode), .sh_hold_req(sh_hold_req),
        .sdo(sdo), .sdo_oe(sdo_oe), .conv_busy(conv_busy), .ana(ana));
    sadc_host host (.sys_clk(sys_clk), .data_line(data_line),
        .cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in));

    assign data_line = sdo_oe ? sdo : 1'bz; // Three-state output
    // Analog side: comparator high while the input is at or above the trial
    assign cmp_in = (vin >= ana.dac);

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    // ******************************************************
    // Conversion monitor: length, channel, hold state, start time
    // ******************************************************
    always @(posedge sys_clk) begin
        if (conv_busy === 1'b1) begin
            if (run == 0) begin
                mux_seen <= ana.mux_sel;
                t_busy <= $time;
            end
            if (run == 5) hold_seen <= ana.hold;
            run <= run + 1;
        end else if (run != 0) begin
            busy_len <= run;
            run <= 0;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Frame, then judge the result, the idle line and the conversion
    task automatic do_frame(input logic [7:0] addr, input logic [7:0] exp,
                            input logic [4:0] chan);
        logic [7:0] rd;
        logic       z_after;
        logic       prompt;
        host.frame(addr, rd, z_after);
        check({8'h00, rd}, {8'h00, exp}); // Result bits
        check({15'h0000, z_after}, {15'h0000, 1'bz}); // Idle floats
        for (int k = 0; conv_busy !== 1'b0; k++) begin
            if (k == 60) begin
                err_count++;
                complete_run();
            end
            @(negedge sys_clk);
        end
        @(negedge sys_clk);
        check(16'(busy_len), 16'(SADC_CONV_CYCLES)); // Span
        check({11'h000, mux_seen}, {11'h000, chan}); // Channel
        prompt = (t_busy > host.t_fall8) && (t_busy < host.t_fall8 + 200);
        check({15'h0000, prompt}, 16'h0001); // Starts after 8th fall
    endtask : do_frame

    task automatic scn_reset;
        check({sdo_oe, conv_busy, ana}, 16'h0000); // Quiet in reset
        check({15'h0000, data_line}, {15'h0000, 1'bz}); // Released
    endtask : scn_reset

    task automatic scn_first;
        vin = 8'hA5;
        do_frame(8'h05, 8'h00, 5'h05);
    endtask : scn_first

    task automatic scn_select;
        vin = 8'hFF;
        do_frame(8'h1F, 8'hA5, 5'h13); // Beyond 19 is self
        vin = 8'h00;
        do_frame(8'h13, 8'hFF, 5'h13); // Self-test channel addressed directly
    endtask : scn_select

    task automatic scn_hold;
        vin = 8'h80;
        sh_host_mode = 1'b1;
        sh_hold_req = 1'b1;
        do_frame(8'h02, 8'h00, 5'h02); // Under range
        check({15'h0000, hold_seen}, 16'h0001); // Host timed hold
        sh_host_mode = 1'b0;
        do_frame(8'h0A, 8'h80, 5'h0A);
        check({15'h0000, hold_seen}, 16'h0000); // Auto tracks
    endtask : scn_hold

    initial begin
        resetn = 1'b0;
        sh_host_mode = 1'b0;
        sh_hold_req = 1'b0;
        vin = 8'h00;
        err_count = 0;
        samples_checked = 0;
        run = 0;
        busy_len = 0;
        repeat (8) @(negedge sys_clk);
        scn_reset();
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
        scn_first();
        scn_select();
        scn_hold();
        complete_run();
    end
endmodule : serial_adc_sequencer_test
